// ### pkg/rcdf_pkg.sv
// Constants, register map and types for the RAM coefficient decimating FIR stage
//
// Behaviour
// - Tap count register holds taps minus one; 19 means 20 taps.
// - At most 64 taps asymmetric, 128 taps symmetric.
// - Decimation 1 to 16 from a 4-bit field holding factor minus one.
// - 20-bit samples in and out; 20-bit coefficients here, 14-bit in preceding stage.
// - Bypass passes input samples unchanged to output, with no scaling.
// - 2-bit scale: 00 -18.06 dB, 01 -12.04 dB, 10 -6.02 dB, 11 none.
// - Symmetry bit: full response computed from half the stored response.
// - Several coefficient sets in RAM; offset register picks the active one.
// - Offset change mid-sample takes effect from the next output sample.
// - 4-bit decimation phase selects which input phase produces output.
// - Two multipliers, I and Q, one tap each per clock cycle.
// - Input at preceding stage rate, output at that rate over decimation.
// - Each coefficient write advances RAM address from start toward stop; here only a write that carries lane 2 steps it.
// - Each coefficient read advances the RAM address the same way.
// - Single location: start equals stop, then one coefficient write.

package rcdf_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int DATA_W = 20;
	localparam int COEF_W = 20; // The preceding stage uses 14
	localparam int COEF_FRAC = 19; // Coefficients are signed fractions
	localparam int ACC_W = 47; // Product plus 7 bits of tap growth
	localparam int RAM_DEPTH = 64;
	localparam int HIST_DEPTH = 128;

	// ----------------------------------------------------------------
	// Register byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_TAPS = 8'h04;
	localparam logic [7:0] ADDR_OFFSET = 8'h08;
	localparam logic [7:0] ADDR_START = 8'h0C;
	localparam logic [7:0] ADDR_STOP = 8'h10;
	localparam logic [7:0] ADDR_COEFF = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;

	// ----------------------------------------------------------------
	// Control and status field positions
	// ----------------------------------------------------------------
	localparam int CTRL_BYPASS = 0;
	localparam int CTRL_SYM = 1;
	localparam int CTRL_SCALE_LSB = 2;
	localparam int CTRL_DEC_LSB = 4;
	localparam int CTRL_PHASE_LSB = 8;
	localparam int STAT_BUSY = 6;
	localparam int STAT_OVERRUN = 7;

	// ----------------------------------------------------------------
	// Reset values and limits
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_RST = 12'h00C; // Scale 11, filter active
	localparam logic [6:0] TAPS_RST = 7'h00;
	localparam logic [5:0] ADDR_RST = 6'h00;
	localparam logic [6:0] MAX_ASYM_TAPS = 7'h3F; // 64 taps minus one
	localparam logic [1:0] SCALE_SHIFT_MAX = 2'h3;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_RUN = 3'b010,
		ST_DONE = 3'b100
	} rcdf_state_t;

endpackage

// ### verif/rcdf_chk_sva.sv
// Assertion checker for the decimating coefficient filter stage
`timescale 1ns/1ps
`default_nettype none
module rcdf_chk (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// APB
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	input wire logic [31:0] PRDATA,
	// Streams
	input wire logic IN_VALID,
	input wire logic [19:0] IN_I,
	input wire logic [19:0] IN_Q,
	input wire logic OUT_VALID,
	input wire logic [19:0] OUT_I,
	input wire logic [19:0] OUT_Q
);
	logic [11:0] ctrl;
	logic [6:0] taps;
	logic [5:0] start;
	logic [5:0] stop;
	logic [5:0] ptr;
	logic [3:0] ph;
	logic [7:0] cnt;
	logic [7:0] due;
	logic acc;
	logic fire;
	assign acc = PSEL && PENABLE;
	assign fire = IN_VALID && ph == ctrl[11:8] && !ctrl[0];
	assign due = {1'b0, taps} + 8'h03; // Trigger edge to output edge
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	// Register shadow from completed writes
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			ctrl <= rcdf_pkg::CTRL_RST;
			taps <= rcdf_pkg::TAPS_RST;
			start <= rcdf_pkg::ADDR_RST;
			stop <= rcdf_pkg::ADDR_RST;
		end
		else if (acc && PWRITE && PSTRB[0])
		begin
			if (PADDR == rcdf_pkg::ADDR_CTRL)
				ctrl <= PSTRB[1] ? PWDATA[11:0] : {ctrl[11:8], PWDATA[7:0]};
			if (PADDR == rcdf_pkg::ADDR_TAPS)
				taps <= PWDATA[6:0];
			if (PADDR == rcdf_pkg::ADDR_START)
				start <= PWDATA[5:0];
			if (PADDR == rcdf_pkg::ADDR_STOP)
				stop <= PWDATA[5:0];
		end
	end
	// Pointer moves on reads and on the top lane only, so half-written words never step it
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			ptr <= rcdf_pkg::ADDR_RST;
		else if (acc && PWRITE && PSTRB[0] && PADDR == rcdf_pkg::ADDR_START)
			ptr <= PWDATA[5:0];
		else if (acc && PADDR == rcdf_pkg::ADDR_COEFF && (!PWRITE || PSTRB[2]))
			ptr <= (ptr == stop) ? start : ptr + 6'h01;
	end
	// Decimation phase and cycles since the last trigger
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			ph <= 4'h0;
			cnt <= 8'h00;
		end
		else
		begin
			if (IN_VALID)
				ph <= (ph == ctrl[7:4]) ? 4'h0 : ph + 4'h1;
			cnt <= fire ? 8'h01 : (cnt == due || cnt == 8'h00) ? 8'h00 : cnt + 8'h01;
		end
	end
	sequence s_rd(logic [7:0] a);
		PSEL && !PENABLE && !PWRITE && PADDR == a ##1 acc;
	endsequence
	property p_ptr;
		s_rd(rcdf_pkg::ADDR_STATUS) |-> PRDATA[5:0] == $past(ptr);
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer differs");
	property p_ctrl;
		s_rd(rcdf_pkg::ADDR_CTRL) |-> PRDATA[11:0] == ctrl;
	endproperty
	a_ctrl: assert property (p_ctrl) else $error("control readback differs");
	property p_taps;
		s_rd(rcdf_pkg::ADDR_TAPS) |-> PRDATA[6:0] == taps;
	endproperty
	a_taps: assert property (p_taps) else $error("tap count readback differs");
	property p_due;
		cnt == due && !ctrl[0] |-> OUT_VALID;
	endproperty
	a_due: assert property (p_due) else $error("output missing at its cycle");
	property p_stray;
		OUT_VALID && !ctrl[0] |-> cnt == due;
	endproperty
	a_stray: assert property (p_stray) else $error("output off phase or cycle");
	property p_pulse;
		OUT_VALID && !ctrl[0] |=> !OUT_VALID;
	endproperty
	a_pulse: assert property (p_pulse) else $error("output longer than one cycle");
	property p_bypass;
		ctrl[0] && IN_VALID |=> OUT_VALID && OUT_I == $past(IN_I) && OUT_Q == $past(IN_Q);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass altered sample");
	property p_hold;
		!OUT_VALID |-> $stable(OUT_I) && $stable(OUT_Q);
	endproperty
	a_hold: assert property (p_hold) else $error("output changed between pulses");
endmodule
bind rcdf_top rcdf_chk rcdf_chk_i (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
	.PRDATA(PRDATA), .IN_VALID(IN_VALID), .IN_I(IN_I), .IN_Q(IN_Q),
	.OUT_VALID(OUT_VALID), .OUT_I(OUT_I), .OUT_Q(OUT_Q));
`default_nettype wire

// ### verif/rcdf_src.sv
// Behavioural model of the preceding stage that feeds samples to the filter
`timescale 1ns/1ps
`default_nettype none
module rcdf_src (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Pacing
	input wire logic en,
	input wire logic [7:0] gap,
	// Sample stream
	output logic valid,
	output logic [19:0] i,
	output logic [19:0] q
);
	int seed = 23159;
	logic [7:0] cnt;
	// One sample every gap+1 cycles; lines flip between samples so stale data never looks good
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			valid <= 1'b0;
			cnt <= 8'h00;
			i <= 20'h00000;
			q <= 20'h00000;
		end
		else if (en && cnt == 8'h00)
		begin
			valid <= 1'b1;
			i <= 20'($random(seed));
			q <= 20'($random(seed));
			cnt <= gap;
		end
		else
		begin
			valid <= 1'b0;
			i <= ~i;
			q <= ~q;
			cnt <= (cnt == 8'h00) ? cnt : cnt - 8'h01;
		end
	end
endmodule
`default_nettype wire

// ### verif/test_ram_coeff_decimating_fir.sv
// Self-checking bench for the decimating coefficient filter stage
`timescale 1ns/1ps
`default_nettype none
module test_ram_coeff_decimating_fir;
	logic CORE_CLK = 1'b0;
	logic RST = 1'b0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h00000000;
	logic [3:0] PSTRB = 4'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic IN_VALID;
	logic [19:0] IN_I;
	logic [19:0] IN_Q;
	logic OUT_VALID;
	logic [19:0] OUT_I;
	logic [19:0] OUT_Q;
	logic src_en = 1'b0;
	logic [7:0] gap = 8'h03;
	logic signed [19:0] ram [64];
	logic signed [19:0] hi [128];
	logic signed [19:0] hq [128];
	logic [40:0] expq [$];
	logic [40:0] e;
	logic [31:0] rdat;
	logic err;
	int n_mismatch = 0;
	int comparisons = 0;
	int seed = 23159;
	int nin, ph, ntap, sym, dec, phs, scl, byp, off;
	always #25 CORE_CLK = ~CORE_CLK;
	rcdf_top rcdf_top_i (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .IN_VALID(IN_VALID), .IN_I(IN_I), .IN_Q(IN_Q),
		.OUT_VALID(OUT_VALID), .OUT_I(OUT_I), .OUT_Q(OUT_Q));
	rcdf_src rcdf_src_i (.clk(CORE_CLK), .rst(RST), .en(src_en), .gap(gap),
		.valid(IN_VALID), .i(IN_I), .q(IN_Q));
	task automatic fail(string m);
		n_mismatch++;
		$display("unexpected at %0t: %s", $time, m);
	endtask
	task automatic check(logic [31:0] got, logic [31:0] exp, string m);
		comparisons++;
		if (got !== exp)
			fail(m);
	endtask
	task automatic stop_test();
		$display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// One APB transfer; request held until ready is seen at an edge
	task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic [3:0] s);
		int t = 0;
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		PSTRB <= s;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		@(posedge CORE_CLK);
		while (PREADY !== 1'b1)
		begin
			t++;
			if (t > 16)
				stop_test();
			@(posedge CORE_CLK);
		end
		rdat = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic wr(logic [7:0] a, logic [31:0] d);
		apb(1'b1, a, d, 4'hF);
	endtask
	task automatic rd(logic [7:0] a, logic [31:0] x, string m);
		apb(1'b0, a, 32'h00000000, 4'h0);
		check(rdat, x, m);
	endtask
	// Load coefficients byte by byte, then read them all back
	task automatic load(int a, int cnt);
		logic [19:0] c;
		wr(rcdf_pkg::ADDR_START, a);
		wr(rcdf_pkg::ADDR_STOP, (a + cnt - 1) % 64);
		for (int k = 0; k < cnt; k++)
		begin
			c = 20'($random(seed) % 65536);
			apb(1'b1, rcdf_pkg::ADDR_COEFF, {12'h000, c}, 4'h1);
			apb(1'b1, rcdf_pkg::ADDR_COEFF, {12'h000, c}, 4'h2);
			if (k == 0)
				rd(rcdf_pkg::ADDR_STATUS, a, "pointer moved on low part");
			apb(1'b1, rcdf_pkg::ADDR_COEFF, {12'h000, c}, 4'h4);
			ram[(a + k) % 64] = c;
		end
		rd(rcdf_pkg::ADDR_STATUS, a, "pointer not back at start");
		for (int k = 0; k < cnt; k++)
			rd(rcdf_pkg::ADDR_COEFF, {12'h000, ram[(a + k) % 64]}, "coefficient");
		rd(rcdf_pkg::ADDR_STATUS, a, "pointer after reads");
	endtask
	// Expected filter output for one path
	function automatic logic [19:0] filt(logic signed [19:0] h [128]);
		longint s = 0;
		int l = ntap / 2;
		int kp;
		int a;
		for (int k = 0; k < ntap; k++)
		begin
			kp = (k < l) ? ntap - 1 - k : k;
			a = sym ? off + kp - l : off + ntap - 1 - k;
			s += longint'(ram[a % 64]) * longint'(h[k]);
		end
		s = s >>> (22 - scl);
		s = (s > 524287) ? 524287 : (s < -524288) ? -524288 : s;
		return s[19:0];
	endfunction
	// Notes the expected result of each triggering input; early ones are don't-care
	always @(posedge CORE_CLK)
	begin
		if (IN_VALID === 1'b1 && RST === 1'b0)
		begin
			for (int k = 127; k > 0; k--)
			begin
				hi[k] = hi[k - 1];
				hq[k] = hq[k - 1];
			end
			hi[0] = IN_I;
			hq[0] = IN_Q;
			nin++;
			if (byp != 0)
				expq.push_back({1'b0, IN_I, IN_Q});
			else if (ph == phs)
				expq.push_back({nin < ntap, filt(hi), filt(hq)});
			ph = (ph == dec - 1) ? 0 : ph + 1;
		end
	end
	// Compares each output pulse with the oldest note
	always @(posedge CORE_CLK)
	begin
		if (OUT_VALID === 1'b1)
		begin
			comparisons++;
			if (expq.size() == 0)
				fail("output with none due");
			else
			begin
				e = expq.pop_front();
				if (e[40] === 1'b0 && {OUT_I, OUT_Q} !== e[39:0])
					fail("sample differs");
			end
		end
	end
	task automatic do_reset();
		src_en <= 1'b0;
		RST <= 1'b1;
		repeat (20) @(posedge CORE_CLK);
		RST <= 1'b0;
		nin = 0;
		ph = 0;
	endtask
	// Reset, program one setup, stream ns samples and drain
	task automatic run(int n, int s, int d, int p, int c, int b, int o, int ns);
		{ntap, sym, dec, phs, scl, byp, off} = {n, s, d, p, c, b, o};
		do_reset();
		load(o, s ? n - n / 2 : n);
		wr(rcdf_pkg::ADDR_TAPS, n - 1);
		wr(rcdf_pkg::ADDR_OFFSET, o);
		wr(rcdf_pkg::ADDR_CTRL, (p << 8) | ((d - 1) << 4) | (c << 2) | (s << 1) | b);
		gap <= 8'(n + 3);
		src_en <= 1'b1;
		while (nin < ns)
			@(posedge CORE_CLK);
		src_en <= 1'b0;
		repeat (n + 8) @(posedge CORE_CLK);
		check(expq.size(), 0, "outputs missing");
	endtask
	initial
	begin
		do_reset();
		rd(rcdf_pkg::ADDR_CTRL, {20'h00000, rcdf_pkg::CTRL_RST}, "control reset");
		for (int a = 4; a <= 16; a += 4)
			rd(8'(a), 32'h00000000, "reset value");
		rd(rcdf_pkg::ADDR_STATUS, 32'h00000000, "status reset");
		apb(1'b0, 8'h1C, 32'h00000000, 4'h0);
		check({31'h0, err}, 32'h00000001, "no error on unmapped");
		wr(rcdf_pkg::ADDR_TAPS, 32'hFFFFFFFF);
		rd(rcdf_pkg::ADDR_TAPS, 32'h0000007F, "tap count width");
		run(2, 0, 1, 0, 3, 0, 0, 8);
		for (int c = 0; c < 4; c++)
			run(3, 0, 2, 1, c, 0, 16, 12);
		run(3, 1, 3, 2, 3, 0, 63, 12);
		run(4, 1, 1, 0, 2, 0, 62, 8);
		run(1, 0, 16, 15, 3, 0, 9, 34);
		run(2, 0, 4, 5, 3, 0, 0, 12);
		run(2, 0, 1, 0, 0, 1, 0, 8);
		run(64, 0, 1, 0, 3, 0, 0, 70);
		run(128, 1, 1, 0, 0, 0, 0, 132);
		stop_test();
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (80000) @(posedge CORE_CLK);
		n_mismatch++;
		stop_test();
	end
endmodule
`default_nettype wire

// ### verilog/rcdf_mac.sv
// One multiply-accumulate path with output scaling and saturation
`timescale 1ns/1ps
`default_nettype none

module rcdf_mac (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Tap stream
	input wire logic en,
	input wire logic first,
	input wire logic signed [rcdf_pkg::DATA_W-1:0] sample,
	input wire logic signed [rcdf_pkg::COEF_W-1:0] coeff,
	// Result
	input wire logic [1:0] scale,
	output logic signed [rcdf_pkg::DATA_W-1:0] result
);

	logic signed [rcdf_pkg::ACC_W-1:0] acc;
	logic signed [rcdf_pkg::ACC_W-1:0] prod;
	logic signed [rcdf_pkg::ACC_W-1:0] shifted;
	logic [5:0] shamt;

	// One tap per cycle; the first tap restarts the sum
	assign prod = rcdf_pkg::ACC_W'(sample * coeff);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			acc <= '0;
		else if (en)
			acc <= (first ? '0 : acc) + prod;
	end

	// Each code step below 11 drops one more bit, i.e. 6.02 dB
	always_comb
	begin
		shamt = 6'(rcdf_pkg::COEF_FRAC) + 6'(rcdf_pkg::SCALE_SHIFT_MAX - scale);
		shifted = acc >>> shamt;
		// Saturate rather than wrap: a wrapped peak is far worse than a clip
		if (shifted[rcdf_pkg::ACC_W-1:rcdf_pkg::DATA_W-1] == '0
			|| shifted[rcdf_pkg::ACC_W-1:rcdf_pkg::DATA_W-1] == '1)
			result = shifted[rcdf_pkg::DATA_W-1:0];
		else if (shifted[rcdf_pkg::ACC_W-1])
			result = {1'b1, {(rcdf_pkg::DATA_W-1){1'b0}}};
		else
			result = {1'b0, {(rcdf_pkg::DATA_W-1){1'b1}}};
	end

endmodule

`default_nettype wire

// ### verilog/rcdf_top.sv
// RAM coefficient decimating FIR stage: APB registers, coefficient RAM, I/Q datapath
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module rcdf_top (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [3:0] PSTRB,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Input sample stream from the preceding stage
	input wire logic IN_VALID,
	input wire logic [19:0] IN_I,
	input wire logic [19:0] IN_Q,
	// Output sample stream
	output logic OUT_VALID,
	output logic [19:0] OUT_I,
	output logic [19:0] OUT_Q
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic [11:0] ctrl;
	logic [6:0] tap_count;
	logic [5:0] coeff_offset;
	logic [5:0] start_addr;
	logic [5:0] stop_addr;
	logic [5:0] ram_ptr;
	logic [15:0] coeff_low;
	logic overrun;
	logic [rcdf_pkg::COEF_W-1:0] coeff_ram [0:rcdf_pkg::RAM_DEPTH-1];
	logic [rcdf_pkg::DATA_W-1:0] hist_i [0:rcdf_pkg::HIST_DEPTH-1];
	logic [rcdf_pkg::DATA_W-1:0] hist_q [0:rcdf_pkg::HIST_DEPTH-1];
	logic [6:0] hist_wr;
	logic [3:0] in_cnt;
	rcdf_pkg::rcdf_state_t state;
	rcdf_pkg::rcdf_state_t next_state;
	logic [6:0] tap_idx;
	logic [6:0] last_tap;
	logic [6:0] base;
	logic [5:0] off_latched;
	logic sym_latched;
	logic [1:0] scale_latched;
	logic apb_access;
	logic apb_wr;
	logic apb_rd;
	logic sel_ctrl;
	logic sel_taps;
	logic sel_offset;
	logic sel_start;
	logic sel_stop;
	logic sel_coeff;
	logic sel_status;
	logic mapped;
	logic coeff_commit;
	logic coeff_step;
	logic [5:0] next_ptr;
	logic [31:0] read_value;
	logic bypass;
	logic sym;
	logic [3:0] dec_factor_m1;
	logic [3:0] dec_phase;
	logic [6:0] eff_last;
	logic fire;
	logic [6:0] low_cnt;
	logic [6:0] mirror_k;
	logic [6:0] coef_m;
	logic [5:0] coef_addr;
	logic [6:0] samp_addr;
	logic running;
	logic first_tap;
	logic [rcdf_pkg::DATA_W-1:0] scaled [0:1];
	logic [rcdf_pkg::DATA_W-1:0] tap_sample [0:1];

	// ----------------------------------------------------------------
	// Control fields
	// ----------------------------------------------------------------
	assign bypass = ctrl[rcdf_pkg::CTRL_BYPASS];
	assign sym = ctrl[rcdf_pkg::CTRL_SYM];
	assign dec_factor_m1 = ctrl[rcdf_pkg::CTRL_DEC_LSB +: 4];
	assign dec_phase = ctrl[rcdf_pkg::CTRL_PHASE_LSB +: 4];

	// Stored value is taps minus one; asymmetric runs cap at 64 taps
	assign eff_last = (!sym && tap_count > rcdf_pkg::MAX_ASYM_TAPS)
		? rcdf_pkg::MAX_ASYM_TAPS : tap_count;

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	assign apb_access = PSEL & PENABLE;
	assign apb_wr = apb_access & PWRITE;
	assign apb_rd = apb_access & ~PWRITE;
	assign sel_ctrl = PADDR == rcdf_pkg::ADDR_CTRL;
	assign sel_taps = PADDR == rcdf_pkg::ADDR_TAPS;
	assign sel_offset = PADDR == rcdf_pkg::ADDR_OFFSET;
	assign sel_start = PADDR == rcdf_pkg::ADDR_START;
	assign sel_stop = PADDR == rcdf_pkg::ADDR_STOP;
	assign sel_coeff = PADDR == rcdf_pkg::ADDR_COEFF;
	assign sel_status = PADDR == rcdf_pkg::ADDR_STATUS;
	assign mapped = sel_ctrl | sel_taps | sel_offset | sel_start
		| sel_stop | sel_coeff | sel_status;

	// Zero wait states; unmapped addresses answer with an error
	assign PREADY = 1'b1;
	assign PSLVERR = apb_access & ~mapped;

	// Lane 2 carries the top four bits, so it is the closing part of a split write
	assign coeff_commit = apb_wr & sel_coeff & PSTRB[2];
	// Reads step the pointer exactly as writes do
	assign coeff_step = coeff_commit | (apb_rd & sel_coeff);

	// Wrap back to start once the stop address was used
	assign next_ptr = (ram_ptr == stop_addr) ? start_addr : ram_ptr + 6'h01;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// Control word, honouring byte lanes
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			ctrl <= rcdf_pkg::CTRL_RST;
		else if (apb_wr && sel_ctrl)
		begin
			if (PSTRB[0])
				ctrl[7:0] <= PWDATA[7:0];
			if (PSTRB[1])
				ctrl[11:8] <= PWDATA[11:8];
		end
	end

	// Tap count, offset and address window
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			tap_count <= rcdf_pkg::TAPS_RST;
			coeff_offset <= rcdf_pkg::ADDR_RST;
			start_addr <= rcdf_pkg::ADDR_RST;
			stop_addr <= rcdf_pkg::ADDR_RST;
		end
		else if (apb_wr && PSTRB[0])
		begin
			if (sel_taps)
				tap_count <= PWDATA[6:0];
			if (sel_offset)
				coeff_offset <= PWDATA[5:0];
			if (sel_start)
				start_addr <= PWDATA[5:0];
			if (sel_stop)
				stop_addr <= PWDATA[5:0];
		end
	end

	// Access pointer: reloaded by a start write, stepped by each coefficient read and each coefficient write with lane 2
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			ram_ptr <= rcdf_pkg::ADDR_RST;
		else if (apb_wr && sel_start && PSTRB[0])
			ram_ptr <= PWDATA[5:0];
		else if (coeff_step)
			ram_ptr <= next_ptr;
	end

	// Low sixteen bits wait here until the top part arrives
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			coeff_low <= 16'h0000;
		else if (apb_wr && sel_coeff)
		begin
			if (PSTRB[0])
				coeff_low[7:0] <= PWDATA[7:0];
			if (PSTRB[1])
				coeff_low[15:8] <= PWDATA[15:8];
		end
	end

	// Coefficient RAM write; lanes given in the same beat override the held bytes
	always_ff @(posedge CORE_CLK)
	begin
		if (coeff_commit)
			coeff_ram[ram_ptr] <= {PWDATA[19:16],
				PSTRB[1] ? PWDATA[15:8] : coeff_low[15:8],
				PSTRB[0] ? PWDATA[7:0] : coeff_low[7:0]};
	end

	// Sticky overrun; a new event wins over a software clear in the same cycle
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			overrun <= 1'b0;
		else if (fire && state != rcdf_pkg::ST_IDLE)
			overrun <= 1'b1;
		else if (apb_wr && sel_status && PSTRB[0] && PWDATA[rcdf_pkg::STAT_OVERRUN])
			overrun <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Mux for the addressed register
	always_comb
	begin
		read_value = 32'h0000_0000;
		case (1'b1)
			sel_ctrl: read_value = {20'h00000, ctrl};
			sel_taps: read_value = {25'h0000000, tap_count};
			sel_offset: read_value = {26'h0000000, coeff_offset};
			sel_start: read_value = {26'h0000000, start_addr};
			sel_stop: read_value = {26'h0000000, stop_addr};
			sel_coeff: read_value = {12'h000, coeff_ram[ram_ptr]};
			sel_status: read_value = {24'h000000, overrun,
				state != rcdf_pkg::ST_IDLE, ram_ptr};
			default: read_value = 32'h0000_0000;
		endcase
	end

	// Captured in the setup cycle so the access phase sees a stable word
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			PRDATA <= 32'h0000_0000;
		else if (PSEL && !PENABLE && !PWRITE)
			PRDATA <= read_value;
	end

	// ----------------------------------------------------------------
	// Input history and decimation
	// ----------------------------------------------------------------
	// Phase counter runs at the input rate and wraps at the factor
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			in_cnt <= 4'h0;
		else if (IN_VALID)
			in_cnt <= (in_cnt >= dec_factor_m1) ? 4'h0 : in_cnt + 4'h1;
	end

	// One output per factor inputs, on the programmed phase
	assign fire = IN_VALID & ~bypass & (in_cnt == dec_phase);

	// Circular sample history, newest at hist_wr minus one
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			hist_wr <= 7'h00;
		else if (IN_VALID)
			hist_wr <= hist_wr + 7'h01;
	end

	always_ff @(posedge CORE_CLK)
	begin
		if (IN_VALID)
		begin
			hist_i[hist_wr] <= IN_I;
			hist_q[hist_wr] <= IN_Q;
		end
	end

	// ----------------------------------------------------------------
	// Tap sequencer
	// ----------------------------------------------------------------
	// A trigger while busy is dropped and flagged, since taps exceed the budget
	always_comb
	begin
		next_state = state;
		case (state)
			rcdf_pkg::ST_IDLE: if (fire) next_state = rcdf_pkg::ST_RUN;
			rcdf_pkg::ST_RUN: if (tap_idx == last_tap) next_state = rcdf_pkg::ST_DONE;
			rcdf_pkg::ST_DONE: next_state = rcdf_pkg::ST_IDLE;
			default: next_state = rcdf_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			state <= rcdf_pkg::ST_IDLE;
		else
			state <= next_state;
	end

	// Settings are frozen per output sample; later changes wait for the next one
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			base <= 7'h00;
			last_tap <= 7'h00;
			off_latched <= rcdf_pkg::ADDR_RST;
			sym_latched <= 1'b0;
			scale_latched <= rcdf_pkg::SCALE_SHIFT_MAX;
		end
		else if (state == rcdf_pkg::ST_IDLE && fire)
		begin
			base <= hist_wr + 7'h01;
			last_tap <= eff_last;
			off_latched <= coeff_offset;
			sym_latched <= sym;
			scale_latched <= ctrl[rcdf_pkg::CTRL_SCALE_LSB +: 2];
		end
	end

	// Tap index, one step per clock
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
			tap_idx <= 7'h00;
		else if (state == rcdf_pkg::ST_RUN)
			tap_idx <= tap_idx + 7'h01;
		else
			tap_idx <= 7'h00;
	end

	// ----------------------------------------------------------------
	// Coefficient and sample addressing
	// ----------------------------------------------------------------
	// Asymmetric sets are stored last-first; symmetric halves middle-first
	always_comb
	begin
		// Worked in eight bits: a 128-tap count would wrap to zero in seven
		low_cnt = 7'(({1'b0, last_tap} + 8'h01) >> 1);
		mirror_k = (tap_idx < low_cnt) ? last_tap - tap_idx : tap_idx;
		if (sym_latched)
			coef_m = mirror_k - low_cnt;
		else
			coef_m = last_tap - tap_idx;
		coef_addr = off_latched + coef_m[5:0];
		samp_addr = base - 7'h01 - tap_idx;
	end

	assign running = state == rcdf_pkg::ST_RUN;
	assign first_tap = tap_idx == 7'h00;
	assign tap_sample[0] = hist_i[samp_addr];
	assign tap_sample[1] = hist_q[samp_addr];

	// ----------------------------------------------------------------
	// I and Q multipliers
	// ----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < 2; p++)
		begin : g_path
			rcdf_mac u_mac (
				.clk(CORE_CLK),
				.rst(RST),
				.en(running),
				.first(first_tap),
				.sample(tap_sample[p]),
				.coeff(coeff_ram[coef_addr]),
				.scale(scale_latched),
				.result(scaled[p])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Output stage
	// ----------------------------------------------------------------
	// Bypass forwards each input untouched; otherwise one result per sequence
	always_ff @(posedge CORE_CLK or posedge RST)
	begin
		if (RST)
		begin
			OUT_VALID <= 1'b0;
			OUT_I <= 20'h00000;
			OUT_Q <= 20'h00000;
		end
		else if (bypass)
		begin
			OUT_VALID <= IN_VALID;
			if (IN_VALID)
			begin
				OUT_I <= IN_I;
				OUT_Q <= IN_Q;
			end
		end
		else
		begin
			OUT_VALID <= state == rcdf_pkg::ST_DONE;
			if (state == rcdf_pkg::ST_DONE)
			begin
				OUT_I <= scaled[0];
				OUT_Q <= scaled[1];
			end
		end
	end

endmodule

`default_nettype wire
